// >>> shia_params.svh
`ifndef SHIA_PARAMS_SVH
`define SHIA_PARAMS_SVH
// Global registers
`define SHIA_A_GCTL 8'h23
`define SHIA_A_GSTS 8'h24
// Port page select: [5:4] read port, [3:0] write port mask
`define SHIA_A_PSEL 8'h4C
`define SHIA_A_LSTS1 8'h4D
`define SHIA_A_LSTS2 8'h4E
`define SHIA_A_ICRH 8'hD8
`define SHIA_A_ICRL 8'hD9
`define SHIA_A_ISRH 8'hDA
`define SHIA_A_ISRL 8'hDB
`define SHIA_A_VSTS 8'hE0
`define SHIA_A_GICR 8'hE1
`define SHIA_A_GPST 8'hE2
`define SHIA_A_SEN0 8'hE3
`define SHIA_A_SEN3 8'hE6
`define SHIA_A_RMSK 8'hE7
`define SHIA_A_FMSK 8'hE8
`define SHIA_A_RFLG 8'hE9
`define SHIA_A_FFLG 8'hEA
// Field positions
`define SHIA_B_GEN 7
`define SHIA_B_SEN 3
`define SHIA_B_GPIO 4
// Flag bits cleared by each status read
`define SHIA_C_LO_S1 8'h07
`define SHIA_C_LO_S2 8'h70
`define SHIA_C_LO_VS 8'h08
`define SHIA_C_HI_S1 8'h03
`define SHIA_C_HI_S2 8'h04
// Reset values
`define SHIA_RST_BYTE 8'h00
`define SHIA_RST_PSEL 8'h01
`endif

// >>> shia_pkg.sv
package shia_pkg;
  typedef logic [7:0] shia_byte_t;
  typedef logic [1:0] shia_port_t;
endpackage : shia_pkg

// >>> shia_core.sv
`timescale 1ns/1ps
`include "shia_params.svh"
module shia_core (
  input wire logic clk, // 10 MHz
  input wire logic rst, // Synchronous, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [27:0] rx_evt_lo, // Low events, 7 per port
  input wire logic [11:0] rx_evt_hi, // High events, 3 per port
  input wire logic [3:0] rx_lock, // Lock level per port
  input wire logic [3:0] rx_pass, // Port pass level per port
  input wire logic [15:0] fc_gpio, // Forward GPIOs, 4 per port
  input wire logic [127:0] sensor_word, // Sensor status, 32 per port
  input wire logic [1:0] tx_irq, // Transmit port requests
  output logic irq_out_n // Interrupt pin, low active
);

  function automatic shia_pkg::shia_byte_t shia_sticky(
    input shia_pkg::shia_byte_t q,
    input shia_pkg::shia_byte_t s,
    input shia_pkg::shia_byte_t c);
    // Set beats clear so no event is lost
    return (q & ~c) | s;
  endfunction : shia_sticky

  ////////////////////////////////////////////////////////////////////
  shia_pkg::shia_byte_t gctl_q, psel_q, rdata_q, rdata_d;
  logic irq_n_q, irq_n_d;
  shia_pkg::shia_byte_t lo_q [4];
  shia_pkg::shia_byte_t hi_q [4];
  shia_pkg::shia_byte_t icrh_q [4];
  shia_pkg::shia_byte_t icrl_q [4];
  shia_pkg::shia_byte_t gicr_q [4];
  shia_pkg::shia_byte_t gpst_q [4];
  shia_pkg::shia_byte_t rmsk_q [4];
  shia_pkg::shia_byte_t fmsk_q [4];
  shia_pkg::shia_byte_t rflg_q [4];
  shia_pkg::shia_byte_t fflg_q [4];
  shia_pkg::shia_byte_t senp_q [4];
  logic [3:0] gpp_q [4];
  shia_pkg::shia_byte_t isrh_w [4];
  shia_pkg::shia_byte_t isrl_w [4];
  shia_pkg::shia_byte_t rise_w [4];
  logic [3:0] rx_pend;
  logic [5:0] gsrc;
  logic [7:0] gsts;
  shia_pkg::shia_port_t rsel;

  assign rsel = psel_q[5:4];
  assign gsrc = {tx_irq, rx_pend};
  // Bit 7 follows the port enables; the pin also needs the global enable
  assign gsts = {|(gsrc & gctl_q[5:0]), 1'b0, gsrc};
  assign irq_n_d = ~(gctl_q[`SHIA_B_GEN] & gsts[7]);
  assign irq_out_n = irq_n_q;
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////
  for (genvar p = 0; p < 4; p++) begin : g_port
    localparam shia_pkg::shia_port_t PI = shia_pkg::shia_port_t'(p);
    logic rd_me, wr_me;
    shia_pkg::shia_byte_t clo, chi, gset, fall, sen;
    logic [3:0] gio;
    assign rd_me = reg_rd && (rsel == PI);
    assign wr_me = reg_wr && psel_q[p];
    assign sen = sensor_word[32*p +: 8];
    assign gio = fc_gpio[4*p +: 4];
    // Reads of link or video status clear their flags
    assign clo = ((rd_me && reg_addr == `SHIA_A_LSTS1) ? `SHIA_C_LO_S1 : 8'h00)
      | ((rd_me && reg_addr == `SHIA_A_LSTS2) ? `SHIA_C_LO_S2 : 8'h00)
      | ((rd_me && reg_addr == `SHIA_A_VSTS) ? `SHIA_C_LO_VS : 8'h00);
    assign chi = ((rd_me && reg_addr == `SHIA_A_LSTS1) ? `SHIA_C_HI_S1 : 8'h00)
      | ((rd_me && reg_addr == `SHIA_A_LSTS2) ? `SHIA_C_HI_S2 : 8'h00);
    // Low nibble of the enable picks rising edges, high nibble falling
    assign gset = {4'h0, (gio & ~gpp_q[p] & gicr_q[p][3:0])
      | (~gio & gpp_q[p] & gicr_q[p][7:4])};
    assign rise_w[p] = sen & ~senp_q[p] & rmsk_q[p];
    assign fall = ~sen & senp_q[p] & fmsk_q[p];
    assign isrl_w[p] = lo_q[p];
    assign isrh_w[p] = {3'b000, |gpst_q[p], |(rflg_q[p] | fflg_q[p]),
      hi_q[p][2:0]};
    // A port is pending only for flags whose own enable is set
    assign rx_pend[p] = |((isrh_w[p] & icrh_q[p]) | (isrl_w[p] & icrl_q[p]));
    always_ff @(posedge clk) begin
      if (rst) begin
        lo_q[p] <= `SHIA_RST_BYTE;
        hi_q[p] <= `SHIA_RST_BYTE;
        gpst_q[p] <= `SHIA_RST_BYTE;
        rflg_q[p] <= `SHIA_RST_BYTE;
        fflg_q[p] <= `SHIA_RST_BYTE;
        senp_q[p] <= `SHIA_RST_BYTE;
        gpp_q[p] <= 4'h0;
      end else begin
        // Link and video flags latch with no regard to the enables
        lo_q[p] <= shia_sticky(lo_q[p], {1'b0, rx_evt_lo[7*p +: 7]}, clo);
        hi_q[p] <= shia_sticky(hi_q[p], {5'h00, rx_evt_hi[3*p +: 3]}, chi);
        gpst_q[p] <= shia_sticky(gpst_q[p], gset,
          (rd_me && reg_addr == `SHIA_A_GPST) ? 8'hFF : 8'h00);
        rflg_q[p] <= shia_sticky(rflg_q[p], rise_w[p],
          (rd_me && reg_addr == `SHIA_A_RFLG) ? 8'hFF : 8'h00) & rmsk_q[p];
        fflg_q[p] <= shia_sticky(fflg_q[p], fall,
          (rd_me && reg_addr == `SHIA_A_FFLG) ? 8'hFF : 8'h00) & fmsk_q[p];
        senp_q[p] <= sen;
        gpp_q[p] <= gio;
      end
    end
    // Writes reach every port named in the write mask at once
    always_ff @(posedge clk) begin
      if (rst) begin
        icrh_q[p] <= `SHIA_RST_BYTE;
        icrl_q[p] <= `SHIA_RST_BYTE;
        gicr_q[p] <= `SHIA_RST_BYTE;
        rmsk_q[p] <= `SHIA_RST_BYTE;
        fmsk_q[p] <= `SHIA_RST_BYTE;
      end else if (wr_me) begin
        if (reg_addr == `SHIA_A_ICRH) icrh_q[p] <= reg_wdata;
        if (reg_addr == `SHIA_A_ICRL) icrl_q[p] <= reg_wdata;
        if (reg_addr == `SHIA_A_GICR) gicr_q[p] <= reg_wdata;
        if (reg_addr == `SHIA_A_RMSK) rmsk_q[p] <= reg_wdata;
        if (reg_addr == `SHIA_A_FMSK) fmsk_q[p] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read decode; per-port registers follow the read port select
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == `SHIA_A_GCTL) begin
      rdata_d = gctl_q;
    end else if (reg_addr == `SHIA_A_GSTS) begin
      rdata_d = gsts;
    end else if (reg_addr == `SHIA_A_PSEL) begin
      rdata_d = psel_q;
    end else if (reg_addr == `SHIA_A_LSTS1) begin
      rdata_d = {rsel, hi_q[rsel][0], lo_q[rsel][0], hi_q[rsel][1], lo_q[rsel][2],
        rx_pass[rsel], rx_lock[rsel]};
    end else if (reg_addr == `SHIA_A_LSTS2) begin
      rdata_d = {1'b0, lo_q[rsel][6], hi_q[rsel][2], lo_q[rsel][4], 3'b000,
        lo_q[rsel][5]};
    end else if (reg_addr == `SHIA_A_VSTS) begin
      rdata_d = {7'h00, lo_q[rsel][3]};
    end else if (reg_addr == `SHIA_A_ICRH) begin
      rdata_d = icrh_q[rsel];
    end else if (reg_addr == `SHIA_A_ICRL) begin
      rdata_d = icrl_q[rsel];
    end else if (reg_addr == `SHIA_A_ISRH) begin
      rdata_d = isrh_w[rsel];
    end else if (reg_addr == `SHIA_A_ISRL) begin
      rdata_d = isrl_w[rsel];
    end else if (reg_addr == `SHIA_A_GICR) begin
      rdata_d = gicr_q[rsel];
    end else if (reg_addr == `SHIA_A_GPST) begin
      rdata_d = gpst_q[rsel];
    end else if (reg_addr >= `SHIA_A_SEN0 && reg_addr <= `SHIA_A_SEN3) begin
      rdata_d = sensor_word[32*rsel + 8*(reg_addr - `SHIA_A_SEN0) +: 8];
    end else if (reg_addr == `SHIA_A_RMSK) begin
      rdata_d = rmsk_q[rsel];
    end else if (reg_addr == `SHIA_A_FMSK) begin
      rdata_d = fmsk_q[rsel];
    end else if (reg_addr == `SHIA_A_RFLG) begin
      rdata_d = rflg_q[rsel] & rmsk_q[rsel];
    end else if (reg_addr == `SHIA_A_FFLG) begin
      rdata_d = fflg_q[rsel] & fmsk_q[rsel];
    end
  end

  // Read data is held, so a late look still sees the last read
  always_ff @(posedge clk) begin
    if (rst) begin
      gctl_q <= `SHIA_RST_BYTE;
      psel_q <= `SHIA_RST_PSEL;
      rdata_q <= `SHIA_RST_BYTE;
      irq_n_q <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == `SHIA_A_GCTL) gctl_q <= reg_wdata;
      if (reg_wr && reg_addr == `SHIA_A_PSEL) psel_q <= reg_wdata;
      if (reg_rd) rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pin_low_cause: assert property (!irq_n_d |=> !irq_out_n) else
    $error("pin not asserted for enabled pending source");
  a_pin_gen_off: assert property (!gctl_q[7] |=> irq_out_n) else
    $error("pin asserted with global enable clear");
  a_pin_release: assert property (!(|(gsrc & gctl_q[5:0])) |=> irq_out_n) else
    $error("pin held with nothing enabled pending");
  a_flag_no_enable: assert property (rx_evt_lo[0] |=> lo_q[0][0]) else
    $error("event lost");
  a_cor_clear: assert property (reg_rd && reg_addr == `SHIA_A_LSTS1 && rsel == 2'h0
    && !rx_evt_lo[0] |=> !lo_q[0][0]) else
    $error("first link status read did not clear");
  a_gpio_rise: assert property (fc_gpio[0] && !gpp_q[0][0] && gicr_q[0][0]
    |=> gpst_q[0][0] ##0 isrh_w[0][4]) else
    $error("gpio rise not latched");
  a_sen_summary: assert property (rise_w[0][0] |=> isrh_w[0][3]) else
    $error("sensor summary not set");
  a_sen_masked: assert property (reg_rd && reg_addr == `SHIA_A_RFLG && rsel == 2'h0
    && !rmsk_q[0][0] |=> !reg_rdata[0]) else
    $error("masked sensor flag read nonzero");
  a_gsts_top: assert property (reg_rd && reg_addr == `SHIA_A_GSTS
    |=> reg_rdata[7] == $past(|(gsrc & gctl_q[5:0]))) else
    $error("global flag wrong");

  ////////////////////////////////////////////////////////////////////
  // Port 0 stands for all four except in a_port3_pend, c_sen_fall and the rsel-indexed a_isrl_mirror and a_isrh_mirror; the ports share one generate body

  a_lsts1_hi: assert property (reg_rd && reg_addr == `SHIA_A_LSTS1 && rsel == 2'h0
    && !rx_evt_hi[0] |=> !hi_q[0][0]) else
    $error("first link status read left a control error");

  a_lsts2_clear: assert property (reg_rd && reg_addr == `SHIA_A_LSTS2 && rsel == 2'h0
    && !rx_evt_hi[2] |=> !hi_q[0][2]) else
    $error("second link status read did not clear");

  a_vsts_clear: assert property (reg_rd && reg_addr == `SHIA_A_VSTS && rsel == 2'h0
    && !rx_evt_lo[3] |=> !lo_q[0][3]) else
    $error("video status read did not clear");

  a_sticky_hi: assert property (rx_evt_hi[0]
    |=> hi_q[0][0]) else
    $error("control error event lost");

  a_gpio_fall: assert property (!fc_gpio[0] && gpp_q[0][0] && gicr_q[0][4]
    |=> gpst_q[0][0]) else
    $error("gpio fall not latched");

  a_gpio_clear: assert property (reg_rd && reg_addr == `SHIA_A_GPST && rsel == 2'h0
    && !(|g_port[0].gset) |=> gpst_q[0] == 8'h00) else
    $error("gpio status read did not clear");

  a_isrl_mirror: assert property (reg_rd && reg_addr == `SHIA_A_ISRL
    |=> reg_rdata == $past(isrl_w[rsel])) else
    $error("low summary read wrong");

  a_isrh_mirror: assert property (reg_rd && reg_addr == `SHIA_A_ISRH
    |=> reg_rdata == $past(isrh_w[rsel])) else
    $error("high summary read wrong");

  a_gsts_ports: assert property (reg_rd && reg_addr == `SHIA_A_GSTS
    |=> reg_rdata[6:0] == {1'b0, $past(gsrc)}) else
    $error("global status source bits wrong");

  a_sen_fall: assert property (g_port[0].fall[0]
    |=> fflg_q[0][0]) else
    $error("sensor fall not latched");

  a_sen_byte: assert property (reg_rd && reg_addr == `SHIA_A_SEN0 && rsel == 2'h0
    |=> reg_rdata == $past(sensor_word[7:0])) else
    $error("sensor byte read wrong");

  a_tx_source: assert property (tx_irq[1] && gctl_q[5] && gctl_q[`SHIA_B_GEN]
    |=> !irq_out_n) else
    $error("transmit source did not reach the pin");

  a_enable_gate: assert property (!irq_out_n
    |-> $past(gctl_q[`SHIA_B_GEN] && gsts[7])) else
    $error("pin low without both enables");

  a_port3_pend: assert property (rx_evt_lo[21] && icrl_q[3][0] && !reg_wr
    |=> rx_pend[3]) else
    $error("enabled port event not pending");

  a_rise_masked: assert property (!rmsk_q[0][0]
    |=> !rflg_q[0][0]) else
    $error("sensor flag set with mask clear");

  a_gsts_no_gen: assert property (reg_rd && reg_addr == `SHIA_A_GSTS && !gctl_q[7]
    && rx_pend[0] && gctl_q[0] |=> reg_rdata[7] && reg_rdata[0]) else
    $error("global status hid a source");

  c_pin_fires: cover property (irq_out_n ##1 !irq_out_n);
  c_clear_read: cover property (lo_q[0][0] ##1 reg_rd && reg_addr == `SHIA_A_LSTS1);
  c_sen_fall: cover property (|fflg_q[1]);
  c_gpio_latch: cover property (|gpst_q[0]);
  c_tx_fires: cover property (tx_irq[1] && gctl_q[5] && !irq_out_n);

endmodule : shia_core

// >>> shia_host.sv
`timescale 1ns/1ps
`include "shia_params.svh"
// Host software on the byte-strobe register bus and the pin input
module shia_host (
  input wire logic clk, // Bus clock
  input wire logic irq_out_n, // Interrupt pin as the host sees it
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_wdata // Write data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Idle cycle after each strobe so no signal moves twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask : rd
  // Source enable first, then port enable, global enable last
  task automatic arm(input logic [7:0] icr, input logic [7:0] gctl);
    wr(`SHIA_A_ICRL, icr);
    wr(`SHIA_A_GCTL, {1'b0, gctl[6:0]});
    wr(`SHIA_A_GCTL, gctl);
  endtask : arm
  task automatic wait_pin(input logic e, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      if (irq_out_n === e) ok = 1'b1;
      else begin
        @(posedge clk);
        #1;
      end
    end
  endtask : wait_pin
endmodule : shia_host

// >>> sensor_hub_irq_aggregator_bench.sv
`timescale 1ns/1ps
`include "shia_params.svh"
module sensor_hub_irq_aggregator_bench;
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [27:0] rx_evt_lo;
  logic [11:0] rx_evt_hi;
  logic [3:0] rx_lock;
  logic [3:0] rx_pass;
  logic [15:0] fc_gpio;
  logic [127:0] sensor_word;
  logic [1:0] tx_irq;
  logic irq_out_n;
  int n_fail;
  int checks_done;
  int k;
  logic [15:0] exp_q[$];
  shia_core DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_evt_lo(rx_evt_lo), .rx_evt_hi(rx_evt_hi),
    .rx_lock(rx_lock), .rx_pass(rx_pass), .fc_gpio(fc_gpio), .sensor_word(sensor_word),
    .tx_irq(tx_irq), .irq_out_n(irq_out_n));
  shia_host host (.clk(clk), .irq_out_n(irq_out_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results;
    $display("Checks %0d, errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Mask of zero marks a clearing read whose value is not judged
  task automatic check_byte(input logic [15:0] n);
    if (n[15:8] !== 8'h00) begin
      checks_done++;
      if ((reg_rdata & n[15:8]) !== n[7:0]) begin
        n_fail++;
        $display("MISMATCH %0t read %h expected %h", $time, reg_rdata, n[7:0]);
      end
    end
  endtask : check_byte
  task automatic check_pin(input logic e);
    bit ok;
    host.wait_pin(e, ok);
    checks_done++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %0t pin not at %b", $time, e);
      results();
    end
  endtask : check_pin
  // Read data lands on the edge that samples the strobe; checked 2 ns later
  always @(posedge clk) begin
    if (reg_rd === 1'b1) begin
      #2 check_byte(exp_q.pop_front());
    end
  end
  task automatic rdx(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    host.rd(a);
  endtask : rdx
  task automatic pulse_lo(input int b);
    rx_evt_lo[b] = 1'b1;
    @(posedge clk);
    #1 rx_evt_lo[b] = 1'b0;
  endtask : pulse_lo
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {rx_evt_lo, rx_evt_hi, fc_gpio, tx_irq} = '0;
    n_fail = 0;
    checks_done = 0;
    k = $urandom(32'hd7b4_cee0);
    for (k = 0; k < 4; k++) sensor_word[32*k +: 32] = $urandom();
    sensor_word[7:0] = 8'h00;
    rx_lock = 4'($urandom());
    rx_pass = 4'($urandom());
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    rdx(`SHIA_A_GCTL, 8'h00, 8'hff);
    rdx(`SHIA_A_ICRL, 8'h00, 8'hff);
    rdx(8'h10, 8'h00, 8'hff);
    pulse_lo(0);
    rdx(`SHIA_A_ISRL, 8'h01, 8'hff);
    check_pin(1'b1);
    rdx(`SHIA_A_LSTS1, {4'h1, 2'b00, rx_pass[0], rx_lock[0]}, 8'hff);
    rdx(`SHIA_A_ISRL, 8'h00, 8'hff);
    host.wr(`SHIA_A_PSEL, 8'h0f);
    host.arm(8'h7f, 8'h0f);
    pulse_lo(0);
    rdx(`SHIA_A_GSTS, 8'h81, 8'hff);
    check_pin(1'b1);
    host.wr(`SHIA_A_GCTL, 8'h8f);
    check_pin(1'b0);
    rdx(`SHIA_A_LSTS1, {4'h1, 2'b00, rx_pass[0], rx_lock[0]}, 8'hff);
    check_pin(1'b1);
    for (k = 0; k < 4; k++) begin
      pulse_lo(7*k+3);
      check_pin(1'b0);
      rdx(`SHIA_A_GSTS, 8'h80 | (8'h01 << k), 8'hff);
      host.wr(`SHIA_A_PSEL, {2'b00, 2'(k), 4'hf});
      rdx(`SHIA_A_ISRL, 8'h08, 8'hff);
      rdx(`SHIA_A_LSTS1, {2'(k), 4'h0, rx_pass[k], rx_lock[k]}, 8'hff);
      rdx(`SHIA_A_ISRL, 8'h08, 8'hff);
      rdx(`SHIA_A_VSTS, 8'h01, 8'hff);
      rdx(`SHIA_A_ISRL, 8'h00, 8'hff);
      check_pin(1'b1);
    end
    host.wr(`SHIA_A_PSEL, 8'h0f);
    rx_evt_hi[2] = 1'b1;
    @(posedge clk);
    #1 rx_evt_hi[2] = 1'b0;
    rdx(`SHIA_A_LSTS1, {4'h0, 2'b00, rx_pass[0], rx_lock[0]}, 8'hff);
    rdx(`SHIA_A_ISRH, 8'h04, 8'h07);
    rdx(`SHIA_A_LSTS2, 8'h20, 8'hff);
    rdx(`SHIA_A_ISRH, 8'h00, 8'h07);
    tx_irq = 2'b10;
    host.wr(`SHIA_A_GCTL, 8'hbf);
    check_pin(1'b0);
    rdx(`SHIA_A_GSTS, 8'ha0, 8'hff);
    tx_irq = 2'b01;
    rdx(`SHIA_A_GSTS, 8'h90, 8'hff);
    tx_irq = 2'b00;
    check_pin(1'b1);
    // Remote GPIOs assumed live before enabling; levels held 300 ns
    for (k = 0; k < 2; k++) begin
      host.wr(`SHIA_A_GICR, (k == 0) ? 8'h01 : 8'h10);
      fc_gpio[0] = ~fc_gpio[0];
      repeat (3) @(posedge clk);
      #1;
      rdx(`SHIA_A_GPST, 8'h01, 8'h0f);
      rdx(`SHIA_A_GPST, 8'h00, 8'h0f);
    end
    host.wr(`SHIA_A_ICRH, 8'h08);
    host.wr(`SHIA_A_RMSK, 8'h01);
    sensor_word[0] = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_pin(1'b0);
    rdx(`SHIA_A_ISRH, 8'h08, 8'h08);
    rdx(`SHIA_A_FFLG, 8'h00, 8'hff);
    rdx(`SHIA_A_RFLG, 8'h01, 8'hff);
    rdx(`SHIA_A_RFLG, 8'h00, 8'hff);
    check_pin(1'b1);
    for (k = 0; k < 4; k++) rdx(`SHIA_A_SEN0 + 8'(k), sensor_word[8*k +: 8], 8'hff);
    repeat (4) @(posedge clk);
    results();
  end
endmodule : sensor_hub_irq_aggregator_bench
